// *** amci_map.svh ***
// Offsets, field positions, reset values and timing counts of the command interpreter
`ifndef AMCI_MAP_SVH
`define AMCI_MAP_SVH
// ****************************************************
// Timing
// ****************************************************
`define AMCI_CLK_HZ 125000000
`define AMCI_BAUD_DEF 9600
`define AMCI_BIT_CYCLES (`AMCI_CLK_HZ / `AMCI_BAUD_DEF)
// ****************************************************
// Register map
// ****************************************************
`define AMCI_REG_CTRL 12'h000
`define AMCI_REG_STAT 12'h004
`define AMCI_REG_POS 12'h008
`define AMCI_REG_VEL 12'h00c
`define AMCI_REG_CUR 12'h010
`define AMCI_CTRL_BAUD_LSB 0
`define AMCI_BAUD_SEL_MAX 2'h2
// ****************************************************
// Reset values and limits
// ****************************************************
`define AMCI_RUN_PCT_RST 8'h1e
`define AMCI_HOLD_PCT_RST 8'h0a
`define AMCI_RES_RST 9'h100
`define AMCI_VEL_RST 32'h0004a817
`define AMCI_MA_PER_PCT 12'h014
`define AMCI_PCT_MAX 32'h00000064
`define AMCI_RES_MAX 32'h00000100
`define AMCI_OUT_MAX 32'h00000003
`define AMCI_IN_MAX 32'h00000004
`define AMCI_ARG_LIM 32'h05f5e100
`define AMCI_HOME_IN 2
`define AMCI_INDEX_IN 3
// ****************************************************
// Characters
// ****************************************************
`define AMCI_CH_SLASH 8'h2f
`define AMCI_CH_ZERO 8'h30
`define AMCI_CH_CR 8'h0d
`define AMCI_CH_LF 8'h0a
`define AMCI_CH_RUN 8'h52
`define AMCI_CH_ABS 8'h41
`define AMCI_CH_REL 8'h50
`define AMCI_CH_VEL 8'h56
`define AMCI_CH_RUNI 8'h6d
`define AMCI_CH_HOLDI 8'h68
`define AMCI_CH_RES 8'h6a
`define AMCI_CH_OUT 8'h4a
`define AMCI_CH_WAIT 8'h48
`define AMCI_CH_HOME 8'h5a
`define AMCI_CH_TERM 8'h54
`define AMCI_RSP_OK 8'h40
`define AMCI_RSP_RNG 8'h43
`define AMCI_RSP_BAD 8'h62
`define AMCI_RSP_TRM 8'h60
`endif

// *** amci_pkg.sv ***
// Types shared by the command interpreter files
package amci_pkg;
  typedef struct packed {
    logic [7:0] letter;
    logic [31:0] arg;
  } amci_cmd_s;
  typedef enum logic [1:0] {
    AMCI_STOP_NONE = 2'b00,
    AMCI_STOP_HOME = 2'b01,
    AMCI_STOP_INDEX = 2'b10
  } amci_stop_e;
  typedef struct packed {
    logic [31:0] steps;
    logic dir;
    logic cont;
    amci_stop_e stop_sel;
  } amci_move_s;
  typedef enum logic [1:0] {P_IDLE = 2'b00, P_ADDR = 2'b01, P_BODY = 2'b10} amci_pstate_e;
  typedef enum logic [2:0] {
    E_IDLE = 3'b000, E_FETCH = 3'b001, E_DO = 3'b010, E_MOVE = 3'b011, E_WAIT = 3'b100
  } amci_estate_e;
  typedef enum logic [1:0] {R_IDLE = 2'b00, R_KICK = 2'b01, R_RISE = 2'b10, R_FALL = 2'b11} amci_rstate_e;
endpackage

// *** amci_uart.sv ***
// Serial character receiver and sender, 8 data bits, no parity, one stop bit
`timescale 1ns/1ns
`default_nettype none
module amci_uart #(
  parameter int DIVW = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [DIVW-1:0] div,
  input wire logic rx,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_start,
  output logic tx_busy,
  output logic tx
);
  logic [DIVW-1:0] rx_cnt;
  logic [3:0] rx_bit;
  logic rx_run;
  logic [7:0] rx_sh;
  logic [DIVW-1:0] tx_cnt;
  logic [3:0] tx_bit;
  logic [9:0] tx_sh;
  wire rx_tick = (rx_cnt == '0);
  wire tx_tick = (tx_cnt == '0);
  // ****************************************************
  // Receiver, samples mid-bit
  // ****************************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_run <= 1'b0;
      rx_cnt <= '0;
      rx_bit <= 4'h0;
      rx_sh <= 8'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (!rx_run)
      begin
        if (!rx)
        begin
          rx_run <= 1'b1;
          rx_cnt <= div >> 1;
          rx_bit <= 4'h0;
        end
      end
      else if (rx_tick)
      begin
        rx_cnt <= div - 1'b1;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx)
          rx_run <= 1'b0;
        else if (rx_bit >= 4'h1 && rx_bit <= 4'h8)
          rx_sh <= {rx, rx_sh[7:1]};
        else if (rx_bit == 4'h9)
        begin
          rx_run <= 1'b0;
          rx_valid <= rx;
          rx_data <= rx_sh;
        end
      end
      else
        rx_cnt <= rx_cnt - 1'b1;
    end
  end
  // ****************************************************
  // Sender
  // ****************************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_busy <= 1'b0;
      tx_cnt <= '0;
      tx_bit <= 4'h0;
      tx_sh <= 10'h3ff;
      tx <= 1'b1;
    end
    else if (!tx_busy)
    begin
      tx <= 1'b1;
      if (tx_start)
      begin
        tx_busy <= 1'b1;
        tx_sh <= {1'b1, tx_data, 1'b0};
        tx_cnt <= '0;
        tx_bit <= 4'h0;
      end
    end
    else if (tx_tick)
    begin
      tx <= tx_sh[0];
      tx_sh <= {1'b1, tx_sh[9:1]};
      tx_cnt <= div - 1'b1;
      tx_bit <= tx_bit + 4'h1;
      if (tx_bit == 4'ha)
        tx_busy <= 1'b0;
    end
    else
      tx_cnt <= tx_cnt - 1'b1;
  end
endmodule
`default_nettype wire

// *** amci_top.sv ***
// Addressed ASCII motion command interpreter with APB status and control
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "amci_map.svh"
module amci_top
  import amci_pkg::*;
#(
  parameter int BIT_CYCLES = `AMCI_BIT_CYCLES,
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_rx,
  output logic link_tx,
  output logic link_de,
  input wire logic [3:0] addr_dial,
  input wire logic [1:0] io_in,
  output logic [1:0] io_out,
  output logic [1:0] io_oe_n,
  input wire logic [1:0] sens_in,
  output logic move_req,
  output amci_move_s move_cfg,
  output logic move_stop,
  input wire logic move_step,
  input wire logic move_done,
  output logic [31:0] top_velocity,
  output logic [8:0] step_div,
  output logic [11:0] drive_ma
);
  localparam int AW = $clog2(DEPTH + 1);
  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [8:0] sync1;
  logic [8:0] sync2;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 9'h1ff;
      sync2 <= 9'h1ff;
    end
    else
    begin
      sync1 <= {addr_dial, sens_in, io_in, link_rx};
      sync2 <= sync1;
    end
  end
  wire rx_pin = sync2[0];
  wire [3:0] ins = sync2[4:1];
  wire [3:0] dial = sync2[8:5];
  // ****************************************************
  // Serial link
  // ****************************************************
  logic [1:0] baud_sel;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic tx_start;
  logic tx_busy;
  logic [7:0] tx_byte;
  // Faster rates divide the 9600 bit time; rounding error stays under 1%
  wire [15:0] bit_div = 16'(BIT_CYCLES >> baud_sel);
  amci_uart #(.DIVW(16)) u_uart (
    .clk(pclk),
    .resetn(presetn),
    .div(bit_div),
    .rx(rx_pin),
    .rx_data(rx_byte),
    .rx_valid(rx_valid),
    .tx_data(tx_byte),
    .tx_start(tx_start),
    .tx_busy(tx_busy),
    .tx(link_tx)
  );
  // ****************************************************
  // Parser
  // ****************************************************
  amci_cmd_s cmd_buf [DEPTH];
  amci_pstate_e pstate;
  amci_estate_e estate;
  amci_cmd_s cur;
  logic have_cmd;
  logic err_bad;
  logic err_rng;
  logic first_term;
  logic [AW-1:0] wcnt;
  logic str_done;
  function automatic logic [1:0] amci_check(input amci_cmd_s c);
    logic [1:0] r;
    r = 2'b00;
    case (c.letter)
      `AMCI_CH_ABS, `AMCI_CH_REL, `AMCI_CH_HOME, `AMCI_CH_TERM: r = 2'b00;
      `AMCI_CH_VEL: r = {1'b0, c.arg == 32'h0};
      `AMCI_CH_RUNI, `AMCI_CH_HOLDI: r = {1'b0, c.arg > `AMCI_PCT_MAX};
      `AMCI_CH_RES: r = {1'b0, c.arg == 32'h0 || c.arg > `AMCI_RES_MAX
                         || (c.arg & (c.arg - 32'h1)) != 32'h0};
      `AMCI_CH_OUT: r = {1'b0, c.arg > `AMCI_OUT_MAX};
      `AMCI_CH_WAIT: r = {1'b0, c.arg == 32'h0 || c.arg > `AMCI_IN_MAX};
      default: r = 2'b10;
    endcase
    return r;
  endfunction
  wire exec_active = (estate != E_IDLE);
  wire is_digit = (rx_byte >= `AMCI_CH_ZERO) && (rx_byte <= 8'h39);
  wire is_eol = (rx_byte == `AMCI_CH_CR) || (rx_byte == `AMCI_CH_LF);
  wire addr_hit = (rx_byte == 8'(`AMCI_CH_ZERO + {4'h0, dial}));
  wire [1:0] cur_chk = amci_check(cur);
  wire push = rx_valid && pstate == P_BODY && !is_digit && !is_eol && have_cmd;
  wire buf_full = (wcnt == AW'(DEPTH));
  wire buf_wr = push && !exec_active && !buf_full;
  wire [31:0] arg_x10 = 32'((cur.arg << 3) + (cur.arg << 1) + {28'h0, rx_byte[3:0]});
  always_ff @(posedge pclk)
  begin
    if (buf_wr)
      cmd_buf[wcnt[$clog2(DEPTH)-1:0]] <= cur;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pstate <= P_IDLE;
      cur <= '0;
      have_cmd <= 1'b0;
      err_bad <= 1'b0;
      err_rng <= 1'b0;
      first_term <= 1'b0;
      wcnt <= '0;
      str_done <= 1'b0;
    end
    else
    begin
      str_done <= 1'b0;
      if (push)
      begin
        err_bad <= err_bad | cur_chk[1];
        err_rng <= err_rng | cur_chk[0] | (buf_full & !exec_active);
        if (wcnt == '0)
          first_term <= (cur.letter == `AMCI_CH_TERM);
        if (!buf_full)
          wcnt <= wcnt + 1'b1;
      end
      if (rx_valid)
      begin
        if (rx_byte == `AMCI_CH_SLASH)
          pstate <= P_ADDR;
        else
        begin
          unique case (pstate)
            P_IDLE: pstate <= P_IDLE;
            P_ADDR:
            begin
              pstate <= addr_hit ? P_BODY : P_IDLE;
              have_cmd <= 1'b0;
              err_bad <= 1'b0;
              err_rng <= 1'b0;
              first_term <= 1'b0;
              wcnt <= '0;
            end
            P_BODY:
            begin
              if (is_digit)
              begin
                cur.arg <= arg_x10;
                err_bad <= err_bad | !have_cmd;
                err_rng <= err_rng | (cur.arg >= `AMCI_ARG_LIM);
              end
              else if (rx_byte == `AMCI_CH_RUN)
              begin
                pstate <= P_IDLE;
                str_done <= 1'b1;
                have_cmd <= 1'b0;
              end
              else if (!is_eol)
              begin
                cur.letter <= rx_byte;
                cur.arg <= 32'h0;
                have_cmd <= 1'b1;
              end
            end
            default: pstate <= P_IDLE;
          endcase
        end
      end
    end
  end
  // ****************************************************
  // String outcome
  // ****************************************************
  wire str_ok = str_done && !err_bad && !err_rng;
  wire abort = str_ok && exec_active && first_term;
  wire start_exec = str_ok && !exec_active && wcnt != '0;
  wire [7:0] rsp_sel = err_bad ? `AMCI_RSP_BAD :
                       err_rng ? `AMCI_RSP_RNG :
                       abort ? `AMCI_RSP_TRM :
                       exec_active ? `AMCI_RSP_BAD : `AMCI_RSP_OK;
  // ****************************************************
  // Executor
  // ****************************************************
  logic [AW-1:0] rptr;
  amci_cmd_s ex;
  logic signed [31:0] position;
  logic [7:0] run_pct;
  logic [7:0] hold_pct;
  logic [1:0] wait_sel;
  logic stop_sent;
  wire signed [31:0] abs_delta = $signed(ex.arg) - position;
  wire home_hit = ins[`AMCI_HOME_IN];
  wire index_hit = ins[`AMCI_INDEX_IN];
  wire stop_now = (move_cfg.stop_sel == AMCI_STOP_HOME && home_hit)
                  || (move_cfg.stop_sel == AMCI_STOP_INDEX && index_hit);
  wire [11:0] run_ma = 12'(run_pct * `AMCI_MA_PER_PCT);
  wire [11:0] hold_ma = 12'(hold_pct * `AMCI_MA_PER_PCT);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      position <= 32'sh0;
    else if (move_step)
      position <= move_cfg.dir ? position - 32'sh1 : position + 32'sh1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      drive_ma <= 12'h0;
    else
      drive_ma <= (estate == E_MOVE) ? run_ma : hold_ma;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      estate <= E_IDLE;
      rptr <= '0;
      ex <= '0;
      move_req <= 1'b0;
      move_cfg <= '0;
      move_stop <= 1'b0;
      stop_sent <= 1'b0;
      wait_sel <= 2'h0;
      top_velocity <= `AMCI_VEL_RST;
      step_div <= `AMCI_RES_RST;
      run_pct <= `AMCI_RUN_PCT_RST;
      hold_pct <= `AMCI_HOLD_PCT_RST;
      io_oe_n <= 2'b11;
      io_out <= 2'b00;
    end
    else
    begin
      move_req <= 1'b0;
      move_stop <= 1'b0;
      if (abort)
      begin
        estate <= E_IDLE;
        move_stop <= (estate == E_MOVE);
      end
      else
      begin
        unique case (estate)
          E_IDLE:
          begin
            rptr <= '0;
            if (start_exec)
              estate <= E_FETCH;
          end
          E_FETCH:
          begin
            if (rptr == wcnt)
              estate <= E_IDLE;
            else
            begin
              ex <= cmd_buf[rptr[$clog2(DEPTH)-1:0]];
              rptr <= rptr + 1'b1;
              estate <= E_DO;
            end
          end
          E_DO:
          begin
            estate <= E_FETCH;
            stop_sent <= 1'b0;
            case (ex.letter)
              `AMCI_CH_ABS:
              begin
                move_cfg.steps <= abs_delta[31] ? 32'(-abs_delta) : abs_delta;
                move_cfg.dir <= abs_delta[31];
                move_cfg.cont <= 1'b0;
                move_cfg.stop_sel <= AMCI_STOP_NONE;
                move_req <= (abs_delta != 32'sh0);
                estate <= (abs_delta != 32'sh0) ? E_MOVE : E_FETCH;
              end
              `AMCI_CH_REL, `AMCI_CH_HOME:
              begin
                move_cfg.steps <= ex.arg;
                move_cfg.dir <= 1'b0;
                move_cfg.cont <= (ex.letter == `AMCI_CH_REL && ex.arg == 32'h0);
                move_cfg.stop_sel <= (ex.letter == `AMCI_CH_HOME) ? AMCI_STOP_HOME :
                                     (ex.arg == 32'h0) ? AMCI_STOP_INDEX : AMCI_STOP_NONE;
                move_req <= 1'b1;
                estate <= E_MOVE;
              end
              `AMCI_CH_VEL: top_velocity <= ex.arg;
              `AMCI_CH_RUNI: run_pct <= ex.arg[7:0];
              `AMCI_CH_HOLDI: hold_pct <= ex.arg[7:0];
              `AMCI_CH_RES: step_div <= ex.arg[8:0];
              `AMCI_CH_OUT: io_oe_n <= ex.arg[1:0];
              `AMCI_CH_WAIT:
              begin
                wait_sel <= 2'(ex.arg[2:0] - 3'h1);
                estate <= E_WAIT;
              end
              `AMCI_CH_TERM: estate <= E_IDLE;
              default: estate <= E_FETCH;
            endcase
          end
          E_MOVE:
          begin
            // Stop is sent once; the generator still ends the move with done
            if (stop_now && !stop_sent)
            begin
              move_stop <= 1'b1;
              stop_sent <= 1'b1;
            end
            if (move_done)
              estate <= E_FETCH;
          end
          E_WAIT:
          begin
            if (!ins[wait_sel])
              estate <= E_FETCH;
          end
          default: estate <= E_IDLE;
        endcase
      end
    end
  end
  // ****************************************************
  // Reply sender
  // ****************************************************
  amci_rstate_e rstate;
  logic [2:0] ridx;
  logic [7:0] rcode;
  assign tx_byte = (ridx == 3'h0) ? `AMCI_CH_SLASH :
                   (ridx == 3'h1) ? `AMCI_CH_ZERO :
                   (ridx == 3'h2) ? rcode :
                   (ridx == 3'h3) ? `AMCI_CH_CR : `AMCI_CH_LF;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rstate <= R_IDLE;
      ridx <= 3'h0;
      rcode <= `AMCI_RSP_OK;
      tx_start <= 1'b0;
      link_de <= 1'b0;
    end
    else
    begin
      tx_start <= 1'b0;
      link_de <= (rstate != R_IDLE);
      unique case (rstate)
        R_IDLE:
        begin
          ridx <= 3'h0;
          if (str_done)
          begin
            rcode <= rsp_sel;
            rstate <= R_KICK;
          end
        end
        R_KICK:
        begin
          tx_start <= 1'b1;
          rstate <= R_RISE;
        end
        R_RISE:
          if (tx_busy)
            rstate <= R_FALL;
        R_FALL:
        begin
          if (!tx_busy)
          begin
            ridx <= ridx + 3'h1;
            rstate <= (ridx == 3'h4) ? R_IDLE : R_KICK;
          end
        end
      endcase
    end
  end
  // ****************************************************
  // APB slave
  // ****************************************************
  // Answer one cycle into the access phase keeps all outputs registered
  wire apb_acc = psel && penable && !pready;
  wire apb_hit = (paddr == `AMCI_REG_CTRL) || (paddr == `AMCI_REG_STAT)
                 || (paddr == `AMCI_REG_POS) || (paddr == `AMCI_REG_VEL)
                 || (paddr == `AMCI_REG_CUR);
  wire apb_ro = (paddr != `AMCI_REG_CTRL);
  wire [31:0] stat_val = {16'h0, rcode, 1'b0, estate, link_de, 3'(wcnt >> 2)};
  wire [31:0] rd_val = (paddr == `AMCI_REG_CTRL) ? {30'h0, baud_sel} :
                       (paddr == `AMCI_REG_STAT) ? stat_val :
                       (paddr == `AMCI_REG_POS) ? position :
                       (paddr == `AMCI_REG_VEL) ? top_velocity :
                       (paddr == `AMCI_REG_CUR) ? {7'h0, step_div, run_pct, hold_pct} :
                       32'h0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      baud_sel <= 2'h0;
    end
    else
    begin
      pready <= apb_acc;
      pslverr <= apb_acc && (!apb_hit || (pwrite && apb_ro));
      prdata <= (apb_acc && !pwrite) ? rd_val : 32'h0;
      if (apb_acc && pwrite && paddr == `AMCI_REG_CTRL)
        baud_sel <= (pwdata[1:0] > `AMCI_BAUD_SEL_MAX) ? `AMCI_BAUD_SEL_MAX : pwdata[1:0];
    end
  end
endmodule
`default_nettype wire

// *** amci_host.sv ***
// Host model on the serial link: sends command lines, collects replies
`timescale 1ns/1ns
`default_nettype none
module amci_host #(
  parameter int BIT = 16
) (
  input wire logic pclk,
  input wire logic link_tx,
  input wire logic link_de,
  output logic link_rx
);
  // Undriven line idles high through the bus failsafe bias
  wire line_q = link_de ? link_tx : 1'b1;
  logic [7:0] rx_q[$];
  logic [7:0] b;
  logic [9:0] f;
  initial link_rx = 1'b1;
  // Start low, eight bits LSB first, stop high, idle high
  task automatic send(input logic [7:0] c);
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      link_rx <= f[i];
      repeat (BIT) @(posedge pclk);
    end
  endtask
  // Line closes with CR and LF after the run letter
  task automatic line(input string s);
    foreach (s[i])
      send(s[i]);
    send(8'h0d);
    send(8'h0a);
  endtask
  // Sample mid-bit so small phase slips do not matter
  initial
  forever
  begin
    @(posedge pclk iff line_q === 1'b0);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge pclk);
      b[i] = line_q;
    end
    repeat (BIT) @(posedge pclk);
    rx_q.push_back(b);
  end
endmodule
`default_nettype wire

// *** amci_top_checker.sv ***
// Port assertions of the command interpreter
`timescale 1ns/1ns
`default_nettype none
module amci_top_checker #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic link_tx,
  input wire logic link_de,
  input wire logic [1:0] io_out,
  input wire logic move_req,
  input wire logic move_stop,
  input wire logic [8:0] step_div,
  input wire logic [11:0] drive_ma
);
  logic [31:0] de_cnt;
  // Reply spans hundreds of cycles, too long for a repetition
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      de_cnt <= 32'h0;
    else
      de_cnt <= link_de ? de_cnt + 32'h1 : 32'h0;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  io_ground_a: assert property (io_out == 2'h0)
    else $error("io line driven high");
  div_legal_a: assert property ($onehot(step_div))
    else $error("step division not a power of two");
  ma_scale_a: assert property (drive_ma % 12'h014 == 12'h0 && drive_ma <= 12'h7d0)
    else $error("drive current off scale");
  bus_quiet_a: assert property (!link_de |-> link_tx)
    else $error("line active without enable");
  reply_start_a: assert property ($rose(link_de) |-> ##[0:8] !link_tx)
    else $error("no start bit after enable");
  reply_len_a: assert property ($fell(link_de) |-> de_cnt >= 32'(12 * BIT_CYCLES))
    else $error("reply too short");
  req_pulse_a: assert property (move_req |=> !move_req)
    else $error("move request held");
  stop_alone_a: assert property (move_stop |-> !move_req)
    else $error("stop with move request");
endmodule
bind amci_top amci_top_checker #(.BIT_CYCLES(BIT_CYCLES)) i_amci_top_checker (.pclk, .presetn,
  .psel, .penable, .pready, .link_tx, .link_de, .io_out, .move_req, .move_stop, .step_div,
  .drive_ma);
`default_nettype wire

// *** tb_amci_top.sv ***
// Self-checking bench of the command interpreter
`timescale 1ns/1ns
`default_nettype none
`include "amci_map.svh"
module tb_amci_top
  import amci_pkg::*;
;
  localparam int BIT = 16;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] addr_dial = 4'h1;
  logic [1:0] io_in = 2'h3;
  logic [1:0] sens_in = 2'h0;
  logic move_done = 1'b0;
  logic move_step = 1'b0;
  logic pready, pslverr, link_rx, link_tx, link_de, move_req, move_stop, err;
  logic [31:0] prdata, top_velocity, rd;
  logic [1:0] io_out, io_oe_n;
  logic [8:0] step_div;
  logic [11:0] drive_ma, ma_mv;
  amci_move_s move_cfg, cfg;
  int failures = 0;
  int n_compared = 0;
  int pend = 0;
  int n_stop = 0;
  always #4 pclk = ~pclk;
  amci_top #(.BIT_CYCLES(BIT)) i_amci_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link_rx, .link_tx, .link_de, .addr_dial, .io_in,
    .io_out, .io_oe_n, .sens_in, .move_req, .move_cfg, .move_stop, .move_step,
    .move_done, .top_velocity, .step_div, .drive_ma);
  amci_host #(.BIT(BIT)) i_amci_host (.pclk, .link_tx, .link_de, .link_rx);
  // Step generator stand-in: one step a cycle, so position follows the moves
  always @(posedge pclk)
  begin
    move_done <= pend == 1;
    move_step <= pend > 0;
    n_stop <= n_stop + int'(move_stop);
    if (move_req)
      cfg <= move_cfg;
    if (move_done)
      ma_mv <= drive_ma;
    if (move_stop)
      pend <= 6;
    else if (move_req && !move_cfg.cont)
      pend <= int'(move_cfg.steps);
    else if (pend > 0)
      pend <= pend - 1;
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic reply(input logic [7:0] code);
    repeat (4000)
      if (i_amci_host.rx_q.size() < 5)
        @(posedge pclk);
    chk("reply", {i_amci_host.rx_q[0], i_amci_host.rx_q[1], i_amci_host.rx_q[2],
      i_amci_host.rx_q[3]}, {16'h2f30, code, 8'h0d});
    i_amci_host.rx_q.delete();
  endtask
  task automatic t_reset();
    chk("step_div", 32'(step_div), 32'h100);
    chk("drive_ma", 32'(drive_ma), 32'hc8);
    apb(1'b0, `AMCI_REG_CUR, 32'h0);
    chk("cur", rd, 32'h01001e0a);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b1, `AMCI_REG_VEL, 32'h5);
    chk("ro write", {31'h0, err}, 32'h1);
    apb(1'b1, `AMCI_REG_CTRL, 32'h3);
    apb(1'b0, `AMCI_REG_CTRL, 32'h0);
    chk("baud clamp", rd, 32'h2);
    apb(1'b1, `AMCI_REG_CTRL, 32'h0);
  endtask
  task automatic t_setup();
    i_amci_host.line("/1V1000m50h20j2R");
    reply(`AMCI_RSP_OK);
    chk("velocity", top_velocity, 32'h3e8);
    chk("step_div", 32'(step_div), 32'h2);
    chk("hold ma", 32'(drive_ma), 32'h190);
    apb(1'b0, `AMCI_REG_CUR, 32'h0);
    chk("cur", rd, 32'h00023214);
    i_amci_host.line("/2V5R");
    repeat (1000) @(posedge pclk);
    chk("stray reply", 32'(i_amci_host.rx_q.size()), 32'h0);
    chk("velocity", top_velocity, 32'h3e8);
  endtask
  task automatic t_move();
    i_amci_host.line("/1P800R");
    reply(`AMCI_RSP_OK);
    wait (pend == 0);
    repeat (4) @(posedge pclk);
    chk("rel", {cfg.steps[30:0], cfg.dir}, 32'h640);
    chk("run ma", 32'(ma_mv), 32'h3e8);
    chk("hold ma", 32'(drive_ma), 32'h190);
    i_amci_host.line("/1A10000R");
    reply(`AMCI_RSP_OK);
    wait (pend == 0);
    chk("abs", cfg.steps, 32'h23f0);
    apb(1'b0, `AMCI_REG_POS, 32'h0);
    chk("position", rd, 32'h2710);
  endtask
  task automatic t_io();
    i_amci_host.line("/1H01J0R");
    reply(`AMCI_RSP_OK);
    chk("io held", 32'(io_oe_n), 32'h3);
    io_in <= 2'h2;
    repeat (8) @(posedge pclk);
    chk("io drive", 32'(io_oe_n), 32'h0);
    i_amci_host.line("/1H02R");
    reply(`AMCI_RSP_OK);
    i_amci_host.line("/1TR");
    reply(`AMCI_RSP_TRM);
    apb(1'b0, `AMCI_REG_STAT, 32'h0);
    chk("abort", 32'(rd[15:4]), 32'h600);
  endtask
  task automatic t_home();
    i_amci_host.line("/1Z500000R");
    reply(`AMCI_RSP_OK);
    chk("home", {cfg.steps[29:0], cfg.stop_sel}, {30'h7a120, AMCI_STOP_HOME});
    sens_in <= 2'h2;
    repeat (20) @(posedge pclk);
    chk("stray stop", n_stop, 0);
    sens_in <= 2'h1;
    repeat (20) @(posedge pclk);
    chk("home stop", n_stop, 1);
    sens_in <= 2'h0;
    wait (pend == 0);
    i_amci_host.line("/1P0R");
    reply(`AMCI_RSP_OK);
    chk("cont", {cfg.cont, cfg.stop_sel}, {1'b1, AMCI_STOP_INDEX});
    sens_in <= 2'h2;
    repeat (20) @(posedge pclk);
    chk("index stop", n_stop, 2);
    sens_in <= 2'h0;
    wait (pend == 0);
    i_amci_host.line("/1m101R");
    reply(`AMCI_RSP_RNG);
    i_amci_host.line("/1X5R");
    reply(`AMCI_RSP_BAD);
  endtask
  task automatic conclude();
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_setup();
    t_move();
    t_io();
    t_home();
    conclude();
  end
  initial
  begin
    repeat (60000) @(posedge pclk);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
